// ===== sec_pkg.sv
package sec_pkg;

	// ------------------------------------------------------------
	// Word layout
	// ------------------------------------------------------------
	localparam int DATA_W = 16;                 // Data bits of one protected half word.
	localparam int CHK_W  = 6;                  // Check bits of one protected half word.
	localparam int HALF_W = DATA_W + CHK_W;     // One stored half: check bits over data.
	localparam int WORD_W = 2 * HALF_W;         // One stored entry holds two halves.
	localparam int BUS_W  = 2 * DATA_W;         // Bus data width.
	localparam int BE_W   = BUS_W / 8;          // Byte enables per bus word.

	// Parity masks, one per check bit, index 0 first.
	localparam logic [DATA_W-1:0] CHK_MASK [CHK_W] = '{
		16'h443f, 16'h13c7, 16'he1d1, 16'hee60, 16'h3e8a, 16'h993c
	};

	// Byte enable patterns that need no read-modify-write.
	localparam logic [BE_W-1:0] BE_ALL = 4'hf;
	localparam logic [BE_W-1:0] BE_LO  = 4'h3;
	localparam logic [BE_W-1:0] BE_HI  = 4'hc;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int REG_AW = 3;
	localparam logic [REG_AW-1:0] REG_CTRL  = 3'h0;   // Interrupt enable.
	localparam logic [REG_AW-1:0] REG_STAT  = 3'h1;   // Ready and error flag.
	localparam logic [REG_AW-1:0] REG_CMD   = 3'h2;   // Debug command and repair disable.
	localparam logic [REG_AW-1:0] REG_PTR   = 3'h3;   // Debug half word pointer.
	localparam logic [REG_AW-1:0] REG_WORD  = 3'h4;   // Debug raw data.
	localparam logic [REG_AW-1:0] REG_CHECK = 3'h5;   // Debug raw check bits.

	localparam int CTRL_IRQ_EN_BIT = 0;
	localparam int STAT_READY_BIT  = 0;
	localparam int STAT_FLAG_BIT   = 1;
	localparam int CMD_RD_BIT      = 0;
	localparam int CMD_WR_BIT      = 1;
	localparam int CMD_RRD_BIT     = 7;

	// ------------------------------------------------------------
	// Controller states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_INIT, ST_IDLE, ST_READ, ST_RMW, ST_GAP, ST_DBG_RD
	} sec_state_t;

endpackage

// ===== sec_mem_if.sv
// Port between the controller and the storage array.
interface sec_mem_if #(parameter int ADDR_W = 8);
	import sec_pkg::*;
	logic                en;     // Access strobe.
	logic                we;     // Write when high, read when low.
	logic [1:0]          wmask;  // Half select for writes.
	logic [ADDR_W-1:0]   addr;   // Entry index.
	logic [WORD_W-1:0]   wdata;  // Entry to store.
	logic [WORD_W-1:0]   rdata;  // Entry read, one cycle after the strobe.
	modport ctrl (output en, we, wmask, addr, wdata, input rdata);
	modport mem  (input en, we, wmask, addr, wdata, output rdata);
endinterface

// ===== sec_ecc.sv
// Check bit generator and single error corrector for one half word.
module sec_ecc (
	// Stored or new data.
	input  wire logic [sec_pkg::DATA_W-1:0] data_i,
	input  wire logic [sec_pkg::CHK_W-1:0]  chk_i,
	// Results.
	output logic      [sec_pkg::CHK_W-1:0]  gen_o,
	output logic      [sec_pkg::DATA_W-1:0] data_o,
	output logic                            single_o,
	output logic                            double_o
);
	import sec_pkg::*;

	logic [CHK_W-1:0]  syn;             // Syndrome.
	logic [CHK_W-1:0]  col [DATA_W];    // Syndrome of each data bit.
	logic [DATA_W-1:0] flip;            // Data bit to correct.

	genvar c, b;
	generate
		// Each check bit is the inverted parity of its masked data.
		for (c = 0; c < CHK_W; c++) begin : g_chk
			assign gen_o[c] = ~(^(data_i & CHK_MASK[c]));
			for (b = 0; b < DATA_W; b++) begin : g_col
				assign col[b][c] = CHK_MASK[c][b];
			end
		end
		// A syndrome equal to a data column points at that bit.
		for (b = 0; b < DATA_W; b++) begin : g_flip
			assign flip[b] = (syn == col[b]);
		end
	endgenerate

	assign syn      = gen_o ^ chk_i;
	assign data_o   = data_i ^ flip;
	// A single check bit error shows as a one-hot syndrome.
	assign single_o = (|flip) | $onehot(syn);
	assign double_o = (|syn) & ~single_o;
endmodule

// ===== sec_sram.sv
// Storage array with per-half write and registered read.
module sec_sram #(parameter int ADDR_W = 8) (
	input wire logic clk_i,
	sec_mem_if.mem   port
);
	import sec_pkg::*;

	logic [WORD_W-1:0] mem [2**ADDR_W];  // Array contents.

	// Writes store the selected halves, reads return the entry next cycle.
	always_ff @(posedge clk_i) begin
		if (port.en) begin
			if (port.we) begin
				for (int h = 0; h < 2; h++) begin
					if (port.wmask[h]) begin
						mem[port.addr][h*HALF_W +: HALF_W] <= port.wdata[h*HALF_W +: HALF_W];
					end
				end
			end else begin
				port.rdata <= mem[port.addr];
			end
		end
	end
endmodule

// ===== sec_ctrl.sv
//
// Behaviour
// RULE1 - Partial or unaligned write uses read-modify-write.
// RULE2 - Single error in RMW: merge corrected, write, flag.
// RULE3 - Double error in RMW: no write, report.
// RULE4 - Reads are checked, corrected data returned.
// RULE5 - Single error read writes corrected word back.
// RULE6 - Single error read always sets flag.
// RULE7 - Double error read marks data invalid.
// RULE8 - Power-up fills memory with zero and checks.
// RULE9 - Access refused and ready clear during fill.
// RULE10 - Check bits 0..2 from three parity masks.
// RULE11 - Check bits 3..5 from three parity masks.
// RULE12 - Debug access has lowest memory priority.
// RULE13 - Debug request during fill waits for it.
// RULE14 - Repair disabled: correct and flag, no write.
// RULE15 - Debug command set ignored while one pending.
// RULE16 - Debug write stores raw word and check.
// RULE17 - Debug read loads raw word and check.
// RULE18 - Debug read never checks, flags or repairs.
// RULE19 - Both commands set: only write is done.
// RULE20 - Software polls commands clear before new one.
// RULE21 - Aligned 2 or 4 byte write in one cycle.
// RULE22 - Read after repair is delayed one cycle.
// RULE23 - Single error raises interrupt when enabled.
// RULE24 - Sticky flag; irq is flag and enable.
module sec_ctrl #(
	parameter int ADDR_W = 8                         // Entry address width.
) (
	// Clock and reset.
	input  wire logic                          CLK_SYS_I,
	input  wire logic                          RESETN_I,
	// System bus request, held until acknowledged.
	input  wire logic                          BUS_REQ_I,
	input  wire logic                          BUS_WE_I,
	input  wire logic [ADDR_W-1:0]             BUS_ADDR_I,
	input  wire logic [sec_pkg::BE_W-1:0]      BUS_BE_I,
	input  wire logic [sec_pkg::BUS_W-1:0]     BUS_WDATA_I,
	// System bus answer.
	output logic                               BUS_ACK_O,
	output logic [sec_pkg::BUS_W-1:0]          BUS_RDATA_O,
	output logic                               BUS_RDERR_O,
	output logic                               BUS_WRERR_O,
	output logic                               BUS_READY_O,
	// Register port.
	input  wire logic [sec_pkg::REG_AW-1:0]    REG_ADDR_I,
	input  wire logic [sec_pkg::BUS_W-1:0]     REG_WDATA_I,
	input  wire logic                          REG_WR_I,
	input  wire logic                          REG_RD_I,
	output logic [sec_pkg::BUS_W-1:0]          REG_RDATA_O,
	// Single error interrupt request.
	output logic                               IRQ_O
);
	import sec_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		sec_state_t         state;        // Controller state.
		logic [ADDR_W-1:0]  init_cnt;     // Fill address.
		logic               ready;        // Fill finished.
		logic               ack;          // Bus answer pulse.
		logic               rderr;        // Read data invalid.
		logic               wrerr;        // Write dropped.
		logic [BUS_W-1:0]   rdata;        // Bus read data.
		logic               flag;         // Sticky single error flag.
		logic               irq_en;       // Single error interrupt enable.
		logic               irq;          // Interrupt request.
		logic               rrd_dis;      // Read repair disable.
		logic               dbg_wr;       // Debug write pending.
		logic               dbg_rd;       // Debug read pending.
		logic [ADDR_W:0]    ptr;          // Debug half word pointer.
		logic [DATA_W-1:0]  dword;        // Debug raw data.
		logic [CHK_W-1:0]   dchk;         // Debug raw check bits.
		logic [BUS_W-1:0]   reg_rdata;    // Register read data.
	} sec_regs_t;

	localparam sec_regs_t RST_VAL = '{state: ST_INIT, default: '0};

	sec_regs_t r_r;                        // Registered state.
	sec_regs_t r_nxt;                      // Next state.

	// ------------------------------------------------------------
	// Memory side signals
	// ------------------------------------------------------------
	sec_mem_if #(.ADDR_W(ADDR_W)) mem_bus ();

	logic              m_en;               // Memory strobe.
	logic              m_we;               // Memory write.
	logic [1:0]        m_mask;             // Halves written.
	logic [ADDR_W-1:0] m_addr;             // Memory address.
	logic              use_raw;            // Store debug check bits as given.
	logic [DATA_W-1:0] wr_dat  [2];        // Data to store per half.
	logic [CHK_W-1:0]  gen_chk [2];        // Check bits generated for wr_dat.
	logic [DATA_W-1:0] rd_dat  [2];        // Raw read data per half.
	logic [CHK_W-1:0]  rd_chk  [2];        // Raw read check bits per half.
	logic [DATA_W-1:0] dec_dat [2];        // Corrected read data per half.
	logic [1:0]        dec_single;         // Single error per half.
	logic [1:0]        dec_double;         // Double error per half.

	// ------------------------------------------------------------
	// Check logic, one encoder and one decoder per half
	// ------------------------------------------------------------
	genvar h;
	generate
		for (h = 0; h < 2; h++) begin : g_half
			assign rd_dat[h] = mem_bus.rdata[h*HALF_W +: DATA_W];
			assign rd_chk[h] = mem_bus.rdata[h*HALF_W+DATA_W +: CHK_W];

			// RULE10 RULE11 encode write data
			sec_ecc u_enc (
				.data_i   (wr_dat[h]),
				.chk_i    ({CHK_W{1'b0}}),
				.gen_o    (gen_chk[h]),
				.data_o   (),
				.single_o (),
				.double_o ()
			);

			// RULE4 check read data
			sec_ecc u_dec (
				.data_i   (rd_dat[h]),
				.chk_i    (rd_chk[h]),
				.gen_o    (),
				.data_o   (dec_dat[h]),
				.single_o (dec_single[h]),
				.double_o (dec_double[h])
			);

			// RULE16 raw check bits on debug write
			assign mem_bus.wdata[h*HALF_W +: HALF_W] = {use_raw ? r_r.dchk : gen_chk[h], wr_dat[h]};
		end
	endgenerate

	assign mem_bus.en    = m_en;
	assign mem_bus.we    = m_we;
	assign mem_bus.wmask = m_mask;
	assign mem_bus.addr  = m_addr;

	// Storage array.
	sec_sram #(.ADDR_W(ADDR_W)) u_sram (
		.clk_i (CLK_SYS_I),
		.port  (mem_bus)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Sequencer, memory control and register file in one process.
	always_comb begin
		r_nxt   = r_r;
		m_en    = 1'b0;
		m_we    = 1'b0;
		m_mask  = 2'b00;
		m_addr  = BUS_ADDR_I;
		use_raw = 1'b0;
		wr_dat[0] = '0;
		wr_dat[1] = '0;
		// Bus answer flags are one-cycle pulses.
		r_nxt.ack   = 1'b0;
		r_nxt.rderr = 1'b0;
		r_nxt.wrerr = 1'b0;

		// Software register writes go first so hardware events override.
		if (REG_WR_I) begin
			unique case (REG_ADDR_I)
				REG_CTRL: begin
					r_nxt.irq_en = REG_WDATA_I[CTRL_IRQ_EN_BIT];
				end
				REG_STAT: begin
					// Writing one clears the flag.
					if (REG_WDATA_I[STAT_FLAG_BIT]) begin
						r_nxt.flag = 1'b0;
					end
				end
				REG_CMD: begin
					r_nxt.rrd_dis = REG_WDATA_I[CMD_RRD_BIT];
					// RULE15 ignore while pending
					if (!r_r.dbg_wr && !r_r.dbg_rd) begin
						// RULE19 write beats read
						if (REG_WDATA_I[CMD_WR_BIT]) begin
							r_nxt.dbg_wr = 1'b1;
						end else if (REG_WDATA_I[CMD_RD_BIT]) begin
							r_nxt.dbg_rd = 1'b1;
						end
					end
				end
				REG_PTR: begin
					r_nxt.ptr = REG_WDATA_I[ADDR_W:0];
				end
				REG_WORD: begin
					r_nxt.dword = REG_WDATA_I[DATA_W-1:0];
				end
				REG_CHECK: begin
					r_nxt.dchk = REG_WDATA_I[CHK_W-1:0];
				end
				default: begin
					// Unmapped offsets ignore writes.
				end
			endcase
		end

		// Register read data stand for one cycle only.
		r_nxt.reg_rdata = '0;
		if (REG_RD_I) begin
			unique case (REG_ADDR_I)
				REG_CTRL: begin
					r_nxt.reg_rdata[CTRL_IRQ_EN_BIT] = r_r.irq_en;
				end
				REG_STAT: begin
					r_nxt.reg_rdata[STAT_READY_BIT] = r_r.ready;
					r_nxt.reg_rdata[STAT_FLAG_BIT]  = r_r.flag;
				end
				REG_CMD: begin
					r_nxt.reg_rdata[CMD_RRD_BIT] = r_r.rrd_dis;
					r_nxt.reg_rdata[CMD_WR_BIT]  = r_r.dbg_wr;
					r_nxt.reg_rdata[CMD_RD_BIT]  = r_r.dbg_rd;
				end
				REG_PTR: begin
					r_nxt.reg_rdata[ADDR_W:0] = r_r.ptr;
				end
				REG_WORD: begin
					r_nxt.reg_rdata[DATA_W-1:0] = r_r.dword;
				end
				REG_CHECK: begin
					r_nxt.reg_rdata[CHK_W-1:0] = r_r.dchk;
				end
				default: begin
					// Unmapped offsets read as zero.
				end
			endcase
		end

		unique case (r_r.state)
			// RULE8 zero fill with valid checks
			ST_INIT: begin
				m_en   = 1'b1;
				m_we   = 1'b1;
				m_mask = 2'b11;
				m_addr = r_r.init_cnt;
				r_nxt.init_cnt = r_r.init_cnt + 1'b1;
				// RULE9 ready only when filled
				if (&r_r.init_cnt) begin
					r_nxt.ready = 1'b1;
					r_nxt.state = ST_IDLE;
				end
			end

			ST_IDLE: begin
				// A request already answered is not taken again.
				if (BUS_REQ_I && !r_r.ack) begin
					m_en = 1'b1;
					if (BUS_WE_I) begin
						// RULE21 aligned write in one cycle
						if (BUS_BE_I == BE_ALL || BUS_BE_I == BE_LO || BUS_BE_I == BE_HI) begin
							m_we      = 1'b1;
							m_mask    = {|BUS_BE_I[3:2], |BUS_BE_I[1:0]};
							wr_dat[0] = BUS_WDATA_I[DATA_W-1:0];
							wr_dat[1] = BUS_WDATA_I[BUS_W-1:DATA_W];
							r_nxt.ack = 1'b1;
						end else begin
							// RULE1 read phase of RMW
							r_nxt.state = ST_RMW;
						end
					end else begin
						r_nxt.state = ST_READ;
					end
				// RULE12 RULE13 debug only when idle
				end else if (r_r.dbg_wr) begin
					// RULE16 raw write to one half
					m_en    = 1'b1;
					m_we    = 1'b1;
					use_raw = 1'b1;
					m_mask  = r_r.ptr[0] ? 2'b10 : 2'b01;
					m_addr  = r_r.ptr[ADDR_W:1];
					wr_dat[0] = r_r.dword;
					wr_dat[1] = r_r.dword;
					r_nxt.dbg_wr = 1'b0;
				end else if (r_r.dbg_rd) begin
					m_en   = 1'b1;
					m_addr = r_r.ptr[ADDR_W:1];
					r_nxt.state = ST_DBG_RD;
				end
			end

			ST_READ: begin
				// RULE4 return corrected data
				r_nxt.rdata = {dec_dat[1], dec_dat[0]};
				r_nxt.ack   = 1'b1;
				// RULE7 mark invalid on double error
				r_nxt.rderr = |dec_double;
				r_nxt.state = ST_IDLE;
				if (|dec_single) begin
					// RULE6 flag on single error
					r_nxt.flag = 1'b1;
					// RULE5 RULE14 repair unless disabled or either half has a double error
					if (!r_r.rrd_dis && !(|dec_double)) begin
						m_en      = 1'b1;
						m_we      = 1'b1;
						m_mask    = 2'b11;
						wr_dat[0] = dec_dat[0];
						wr_dat[1] = dec_dat[1];
						// RULE22 one idle cycle after repair
						r_nxt.state = ST_GAP;
					end
				end
			end

			ST_RMW: begin
				r_nxt.ack   = 1'b1;
				r_nxt.state = ST_IDLE;
				if (|dec_double) begin
					// RULE3 drop the write and report
					r_nxt.wrerr = 1'b1;
				end else begin
					// RULE1 RULE2 merge bytes into corrected data
					m_en   = 1'b1;
					m_we   = 1'b1;
					m_mask = 2'b11;
					for (int i = 0; i < 2; i++) begin
						wr_dat[i][7:0]  = BUS_BE_I[2*i] ? BUS_WDATA_I[16*i +: 8] : dec_dat[i][7:0];
						wr_dat[i][15:8] = BUS_BE_I[2*i+1] ? BUS_WDATA_I[16*i+8 +: 8] : dec_dat[i][15:8];
					end
					if (|dec_single) begin
						r_nxt.flag = 1'b1;
					end
				end
			end

			ST_GAP: begin
				// RULE22 leave only after the answer pulse.
				r_nxt.state = r_r.ack ? ST_GAP : ST_IDLE;
			end

			// RULE17 RULE18 raw load, no check
			ST_DBG_RD: begin
				r_nxt.dword  = rd_dat[r_r.ptr[0]];
				r_nxt.dchk   = rd_chk[r_r.ptr[0]];
				r_nxt.dbg_rd = 1'b0;
				r_nxt.state  = ST_IDLE;
			end
		endcase

		// RULE23 RULE24 request follows flag and enable
		r_nxt.irq = r_nxt.flag & r_nxt.irq_en;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// State register, reset to the fill state.
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			r_r <= RST_VAL;
		end else begin
			r_r <= r_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign BUS_ACK_O   = r_r.ack;
	assign BUS_RDATA_O = r_r.rdata;
	assign BUS_RDERR_O = r_r.rderr;
	assign BUS_WRERR_O = r_r.wrerr;
	assign BUS_READY_O = r_r.ready;
	assign REG_RDATA_O = r_r.reg_rdata;
	assign IRQ_O       = r_r.irq;
endmodule

// ===== sec_ctrl_assertions.sv
module sec_ctrl_chk
	import sec_pkg::*;
#(
	parameter int ADDR_W = 8                     // Entry address width.
) (
	// Clock and reset.
	input wire logic                    CLK_SYS_I,
	input wire logic                    RESETN_I,
	// Bus request.
	input wire logic                    BUS_REQ_I,
	input wire logic                    BUS_WE_I,
	input wire logic [sec_pkg::BE_W-1:0] BUS_BE_I,
	// Bus answer.
	input wire logic                    BUS_ACK_O,
	input wire logic                    BUS_RDERR_O,
	input wire logic                    BUS_WRERR_O,
	input wire logic                    BUS_READY_O
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FILL = 2 ** ADDR_W;           // Entries cleared after reset.
	logic [15:0] fill_cnt_r;                     // Cycles since reset release.
	logic        aligned;                        // Write needs no merge.

	assign aligned = BUS_BE_I inside {BE_ALL, BE_LO, BE_HI};

	// Counts cycles since reset so the fill length can be bounded.
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			fill_cnt_r <= '0;
		end else if (fill_cnt_r != 16'hffff) begin
			fill_cnt_r <= fill_cnt_r + 16'h1;
		end
	end

	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RESETN_I);

	property p_ack_single; BUS_ACK_O |=> !BUS_ACK_O; endproperty
	a_ack_single: assert property (p_ack_single) else $error("ack longer than one cycle");
	property p_no_ack_fill; !BUS_READY_O |-> !BUS_ACK_O; endproperty
	a_no_ack_fill: assert property (p_no_ack_fill) else $error("access served during fill");
	property p_ready_holds; BUS_READY_O |=> BUS_READY_O; endproperty
	a_ready_holds: assert property (p_ready_holds) else $error("ready dropped");
	property p_fill_early; fill_cnt_r < 16'(FILL - 1) |-> !BUS_READY_O; endproperty
	a_fill_early: assert property (p_fill_early) else $error("ready before fill done");
	property p_fill_late; fill_cnt_r == 16'(FILL + 4) |-> BUS_READY_O; endproperty
	a_fill_late: assert property (p_fill_late) else $error("fill too long");
	property p_req_served; BUS_READY_O && BUS_REQ_I && !BUS_ACK_O |-> ##[1:6] BUS_ACK_O; endproperty
	a_req_served: assert property (p_req_served) else $error("bus request starved");
	property p_rderr_read; BUS_RDERR_O |-> BUS_ACK_O && !BUS_WE_I; endproperty
	a_rderr_read: assert property (p_rderr_read) else $error("invalid mark off a read");
	property p_wrerr_rmw; BUS_WRERR_O |-> BUS_ACK_O && BUS_WE_I && !aligned; endproperty
	a_wrerr_rmw: assert property (p_wrerr_rmw) else $error("write error off a merge");
	property p_rmw_two; BUS_ACK_O && BUS_WE_I && !aligned |-> $past(BUS_REQ_I, 2); endproperty
	a_rmw_two: assert property (p_rmw_two) else $error("merge write too fast");
	property p_read_two; BUS_ACK_O && !BUS_WE_I |-> $past(BUS_REQ_I, 2); endproperty
	a_read_two: assert property (p_read_two) else $error("read answered too fast");
endmodule

bind sec_ctrl sec_ctrl_chk #(.ADDR_W(ADDR_W)) chk_u (
	.CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .BUS_REQ_I(BUS_REQ_I), .BUS_WE_I(BUS_WE_I),
	.BUS_BE_I(BUS_BE_I), .BUS_ACK_O(BUS_ACK_O), .BUS_RDERR_O(BUS_RDERR_O),
	.BUS_WRERR_O(BUS_WRERR_O), .BUS_READY_O(BUS_READY_O)
);

// ===== sec_bus_init.sv
// Bus initiator: holds each request until acknowledged, then scrambles the idle lines.
module sec_bus_init
	import sec_pkg::*;
#(
	parameter int ADDR_W = 8                     // Entry address width.
) (
	// Clock.
	input  wire logic                       clk_i,
	// Answer.
	input  wire logic                       ack_i,
	input  wire logic [sec_pkg::BUS_W-1:0]  rdata_i,
	input  wire logic                       rderr_i,
	input  wire logic                       wrerr_i,
	// Request.
	output logic                            req_o,
	output logic                            we_o,
	output logic [ADDR_W-1:0]               addr_o,
	output logic [sec_pkg::BE_W-1:0]        be_o,
	output logic [sec_pkg::BUS_W-1:0]       wdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		req_o = 1'b0;
		we_o = 1'b0;
		addr_o = '0;
		be_o = '0;
		wdata_o = '0;
	end

	// One transfer after an optional idle gap; answer taken in the ack cycle.
	task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [BE_W-1:0] b,
		input logic [BUS_W-1:0] wd, input int gap, output logic [BUS_W-1:0] rd,
		output logic rerr, output logic werr, output logic tmo);
		tmo = 1'b1;
		rd = '0;
		rerr = 1'b0;
		werr = 1'b0;
		repeat (gap + 1) @(posedge clk_i);
		req_o <= 1'b1;
		we_o <= w;
		addr_o <= a;
		be_o <= b;
		wdata_o <= wd;
		for (int n = 0; n < 200; n++) begin
			@(negedge clk_i);
			if (ack_i === 1'b1) begin
				tmo = 1'b0;
				rd = rdata_i;
				rerr = rderr_i;
				werr = wrerr_i;
				break;
			end
		end
		// Released lines show the inverse so stale values are never mistaken for live ones.
		@(posedge clk_i);
		req_o <= 1'b0;
		we_o <= ~w;
		addr_o <= ~a;
		be_o <= ~b;
		wdata_o <= ~wd;
	endtask
endmodule

// ===== test_sram_ecc_controller.sv
`define CHK(got, exp) begin \
	num_checks++; \
	if ((got) !== (exp)) begin \
		error_cnt++; \
		$display("MISMATCH %0t got %h exp %h", $time, got, exp); \
	end \
end

module test_sram_ecc_controller;
	timeunit 1ns;
	timeprecision 1ps;
	import sec_pkg::*;
	localparam int AW = 5;                       // Small array keeps the fill short.
	logic clk = 1'b0, rst_n = 1'b0, req, we, ack, rderr, wrerr, ready, irq;
	logic [AW-1:0] addr;
	logic [3:0] be;
	logic [31:0] wdata, rdata, reg_wdata, reg_rdata, rrd, mdl [2**AW];
	logic [2:0] reg_addr = '0;
	logic reg_wr_s = 1'b0, reg_rd_s = 1'b0;
	int error_cnt = 0, num_checks = 0, seed = 90744;

	always #2.5 clk = ~clk;

	sec_ctrl #(.ADDR_W(AW)) dut_u (.CLK_SYS_I(clk), .RESETN_I(rst_n), .BUS_REQ_I(req), .BUS_WE_I(we),
		.BUS_ADDR_I(addr), .BUS_BE_I(be), .BUS_WDATA_I(wdata), .BUS_ACK_O(ack), .BUS_RDATA_O(rdata),
		.BUS_RDERR_O(rderr), .BUS_WRERR_O(wrerr), .BUS_READY_O(ready), .REG_ADDR_I(reg_addr),
		.REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr_s), .REG_RD_I(reg_rd_s), .REG_RDATA_O(reg_rdata), .IRQ_O(irq));
	sec_bus_init #(.ADDR_W(AW)) init_u (.clk_i(clk), .ack_i(ack), .rdata_i(rdata), .rderr_i(rderr),
		.wrerr_i(wrerr), .req_o(req), .we_o(we), .addr_o(addr), .be_o(be), .wdata_o(wdata));

	// Expected check bits of one half word.
	function automatic logic [5:0] ecc_of(input logic [15:0] d);
		logic [5:0] c;
		for (int i = 0; i < 6; i++) c[i] = ~^(d & CHK_MASK[i]);
		return c;
	endfunction

	// Byte merge of old and new data.
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] b);
		for (int i = 0; i < 4; i++) if (b[i]) o[8*i +: 8] = n[8*i +: 8];
		return o;
	endfunction

	task automatic print_verdict();
		$display("Checks %0d, errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic reg_wr(input logic [2:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr_s <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr_s <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe.
	task automatic reg_rd(input logic [2:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd_s <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd_s <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask

	task automatic bus(input logic w, input logic [AW-1:0] a, input logic [3:0] b, input logic [31:0] wd,
		output logic [31:0] rd, output logic re, output logic werr);
		logic tmo;
		init_u.access(w, a, b, wd, $random(seed) & 1, rd, re, werr, tmo);
		if (tmo) begin
			error_cnt++;
			$display("MISMATCH %0t bus access timed out", $time);
			print_verdict();
		end
	endtask

	task automatic wait_cmd();
		logic [31:0] d;
		for (int n = 0; n < 30; n++) begin
			reg_rd(REG_CMD, d);
			if (d[1:0] === 2'b00) return;
		end
		error_cnt++;
		$display("MISMATCH %0t debug command stuck", $time);
		print_verdict();
	endtask

	task automatic dbg_wr(input logic [AW:0] p, input logic [15:0] d, input logic [5:0] c);
		reg_wr(REG_PTR, 32'(p));
		reg_wr(REG_WORD, {16'h0, d});
		reg_wr(REG_CHECK, {26'h0, c});
		reg_wr(REG_CMD, rrd | 32'h2);
		wait_cmd();
	endtask

	task automatic dbg_rd(input logic [AW:0] p, output logic [15:0] d, output logic [5:0] c);
		logic [31:0] t;
		reg_wr(REG_PTR, 32'(p));
		reg_wr(REG_CMD, rrd | 32'h1);
		wait_cmd();
		reg_rd(REG_WORD, t);
		d = t[15:0];
		reg_rd(REG_CHECK, t);
		c = t[5:0];
	endtask

	// Main sequence: debug during fill, byte-enable sweep, then injected errors.
	initial begin
		logic [31:0] d, r;
		logic re, wx;
		logic [15:0] h, m;
		logic [5:0] c;
		logic [AW-1:0] a;
		rrd = '0;
		foreach (mdl[i]) mdl[i] = '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		reg_wr(REG_PTR, 32'h2);
		reg_wr(REG_WORD, 32'h1234);
		reg_wr(REG_CHECK, {26'h0, ecc_of(16'h1234)});
		reg_wr(REG_CMD, 32'h3);
		reg_wr(REG_CMD, 32'h1);
		reg_rd(REG_CMD, d); `CHK(d, 32'h2)
		reg_rd(REG_STAT, d); `CHK(d[0], 1'b0)
		wait_cmd();
		reg_rd(REG_STAT, d); `CHK(d[0], 1'b1)
		reg_rd(REG_WORD, d); `CHK(d, 32'h1234)
		mdl[1] = 32'h1234;
		bus(1'b0, 5'd1, 4'hf, 32'h0, r, re, wx); `CHK(r, 32'h1234)
		dbg_rd(6'd1, h, c); `CHK({h, c}, {16'h0, ecc_of(16'h0)})
		`CHK(c, 6'h3f)
		for (int i = 1; i < 16; i++) begin
			a = AW'($random(seed));
			d = $random(seed);
			bus(1'b1, a, 4'(i), d, r, re, wx); `CHK(wx, 1'b0)
			mdl[a] = merge(mdl[a], d, 4'(i));
			bus(1'b0, a, 4'hf, 32'h0, r, re, wx); `CHK(r, mdl[a])
			dbg_rd({a, 1'b1}, h, c); `CHK(c, ecc_of(mdl[a][31:16]))
		end
		reg_wr(REG_CTRL, 32'h1);
		for (int k = 0; k < 2; k++) begin
			rrd = k ? 32'h80 : 32'h0;
			a = AW'(20 + k);
			mdl[a] = $random(seed);
			m = 16'h1 << (k * 5);
			bus(1'b1, a, 4'hf, mdl[a], r, re, wx);
			dbg_wr({a, 1'b0}, mdl[a][15:0] ^ m, ecc_of(mdl[a][15:0]));
			bus(1'b0, a, 4'hf, 32'h0, r, re, wx); `CHK({re, r}, {1'b0, mdl[a]})
			reg_rd(REG_STAT, d); `CHK(d[1], 1'b1)
			`CHK(irq, 1'b1)
			reg_wr(REG_STAT, 32'h2);
			dbg_rd({a, 1'b0}, h, c); `CHK(h, k ? mdl[a][15:0] ^ m : mdl[a][15:0])
			reg_rd(REG_STAT, d); `CHK(d[1], 1'b0)
			`CHK(irq, 1'b0)
		end
		rrd = '0;
		a = AW'(26);
		mdl[a] = $random(seed);
		bus(1'b1, a, 4'hf, mdl[a], r, re, wx);
		dbg_wr({a, 1'b0}, mdl[a][15:0] ^ 16'h0011, ecc_of(mdl[a][15:0]));
		bus(1'b0, a, 4'hf, 32'h0, r, re, wx); `CHK(re, 1'b1)
		bus(1'b1, a, 4'h1, 32'h0, r, re, wx); `CHK(wx, 1'b1)
		dbg_rd({a, 1'b0}, h, c); `CHK(h, mdl[a][15:0] ^ 16'h0011)
		a = AW'(28);
		mdl[a] = $random(seed);
		bus(1'b1, a, 4'hf, mdl[a], r, re, wx);
		dbg_wr({a, 1'b1}, mdl[a][31:16] ^ 16'h4, ecc_of(mdl[a][31:16]));
		d = $random(seed);
		bus(1'b1, a, 4'h1, d, r, re, wx); `CHK(wx, 1'b0)
		mdl[a] = merge(mdl[a], d, 4'h1);
		reg_rd(REG_STAT, d); `CHK(d[1], 1'b1)
		dbg_rd({a, 1'b1}, h, c); `CHK({h, c}, {mdl[a][31:16], ecc_of(mdl[a][31:16])})
		print_verdict();
	end
endmodule
